// [hw/tone_regs_pkg.sv]
// constants shared by the tone control configuration registers
package tone_regs_pkg;
  // ************************************************************
  // register subaddresses
  // ************************************************************
  localparam logic [7:0]  BASS_SET_ADDR     = 8'hDA; // bass corner set select
  localparam logic [7:0]  BASS_GAIN_ADDR    = 8'hDB; // bass gain index select
  localparam logic [7:0]  TREBLE_SET_ADDR   = 8'hDC; // treble corner set select
  localparam logic [7:0]  TREBLE_GAIN_ADDR  = 8'hDD; // treble gain index select
  // ************************************************************
  // field layout and values
  // ************************************************************
  localparam int          NUM_GROUPS        = 4;     // channel groups per register
  localparam int          FIELD_W           = 8;     // one byte per group
  localparam int          CODE_W            = 3;     // corner code bits used
  localparam int          SUBWOOFER_LSB     = 24;    // channel 8 field
  localparam int          SURROUND_LSB      = 16;    // channels 6 and 5 field
  localparam int          REAR_LSB          = 8;     // channels 4 and 3 field
  localparam int          FRONT_LSB         = 0;     // channels 7, 2 and 1 field
  localparam logic [31:0] GAIN_RESET        = 32'h12121212; // 0 dB in every group
  localparam logic [31:0] SET_RESET         = 32'h00000000; // no change in every group
  localparam logic [31:0] TREBLE_SET_MASK   = 32'h07070707; // upper five bits reserved
  localparam logic [7:0]  GAIN_ZERO_DB      = 8'h12; // 0 dB index
  localparam logic [7:0]  GAIN_MAX_INDEX    = 8'h24; // -18 dB, largest legal index
  localparam logic [7:0]  CODE_KEEP         = 8'h00; // keep present corner
  localparam logic [7:0]  CODE_LAST_SET     = 8'h05; // corner set five
  localparam logic [2:0]  CORNER_RESET      = 3'h1;  // corner set in use after reset
endpackage : tone_regs_pkg

// [hw/tone_corner_slot.sv]
// one channel group's corner filter set selection
`timescale 1ns/1ps
module tone_corner_slot
  import tone_regs_pkg::*;
(
  input  wire logic         sys_clk_in,   // control clock
  input  wire logic         nrst_in,      // async reset, active low
  input  wire logic         load_in,      // field written this cycle
  input  wire logic [7:0]   code_in,      // written field value
  output logic      [2:0]   corner_out    // corner set in use, 1..5
);
  // ************************************************************
  // code decode
  // ************************************************************
  // (R2) (R6) codes one to five select, zero and illegal keep
  wire logic code_valid = (code_in != CODE_KEEP) && (code_in <= CODE_LAST_SET);
  wire logic take       = load_in && code_valid;

  // selection flop
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      corner_out <= CORNER_RESET;
    end else if (take) begin
      corner_out <= code_in[2:0];
    end
  end
endmodule : tone_corner_slot

// [hw/tone_control_config_regs.sv]
// bass and treble tone configuration register bank
`timescale 1ns/1ps
// How it works
// (R1) bass set: four byte fields, one per group
// (R2) code zero keeps corner, one-five select
// (R3) host never writes codes six or seven
// (R4) surround field is lineout in six-channel mode
// (R5) treble set: same bytes, low three bits
// (R6) treble code zero keeps, one-five select
// (R7) bass gain: four byte indexes, reset 0x12
// (R8) bass index linear, 0x12 is 0 dB
// (R9) treble gain: same bytes, reset 0x12
// (R10) treble index linear, 0x12 is 0 dB
// (R11) host never writes index above 0x24
// (R12) tone acts only when inline selected
// (R13) bass gain at subaddress 0xDB, four bytes
// (R14) bass set at subaddress 0xDA
// (R15) reads return last written or reset
module tone_control_config_regs
  import tone_regs_pkg::*;
(
  input  wire logic         sys_clk_in,            // control clock, 40 MHz
  input  wire logic         nrst_in,               // async reset, active low
  input  wire logic [7:0]   subaddr_in,            // register subaddress
  input  wire logic         wr_stb_in,             // one-cycle four-byte write
  input  wire logic [31:0]  wr_data_in,            // write word
  input  wire logic         rd_stb_in,             // one-cycle read request
  input  wire logic         tone_inline_in,        // bypass registers set inline
  input  wire logic         six_channel_in,        // six-channel configuration
  output logic      [31:0]  rd_data_out,           // read word
  output logic      [11:0]  bass_corner_out,       // 3 bits per group
  output logic      [11:0]  treble_corner_out,     // 3 bits per group
  output logic      [31:0]  bass_gain_index_out,   // applied bass indexes
  output logic      [31:0]  treble_gain_index_out, // applied treble indexes
  output logic              surround_is_lineout_out // channels 6/5 drive lineout
);
  // ************************************************************
  // storage
  // ************************************************************
  logic [31:0] bass_set_r;     // bass corner set select
  logic [31:0] bass_gain_r;    // bass gain index select
  logic [31:0] treble_set_r;   // treble corner set select
  logic [31:0] treble_gain_r;  // treble gain index select
  logic [31:0] rd_data_nxt;    // read mux
  logic [31:0] bass_eff_nxt;   // applied bass indexes
  logic [31:0] treble_eff_nxt; // applied treble indexes

  // ************************************************************
  // address decode
  // ************************************************************
  // (R14) bass set subaddress
  wire logic hit_bass_set    = (subaddr_in == BASS_SET_ADDR);
  // (R13) bass gain subaddress
  wire logic hit_bass_gain   = (subaddr_in == BASS_GAIN_ADDR);
  wire logic hit_treble_set  = (subaddr_in == TREBLE_SET_ADDR);
  wire logic hit_treble_gain = (subaddr_in == TREBLE_GAIN_ADDR);
  wire logic wr_bass_set     = wr_stb_in && hit_bass_set;
  wire logic wr_treble_set   = wr_stb_in && hit_treble_set;

  // (R15) read mux, unmapped reads as zero
  assign rd_data_nxt = hit_bass_set    ? bass_set_r    :
                       hit_bass_gain   ? bass_gain_r   :
                       hit_treble_set  ? treble_set_r  :
                       hit_treble_gain ? treble_gain_r : 32'h00000000;

  // ************************************************************
  // register writes
  // ************************************************************
  // (R7) gain registers reset to 0 dB, whole word written at once
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bass_set_r    <= SET_RESET;
      bass_gain_r   <= GAIN_RESET;
      treble_set_r  <= SET_RESET;
      treble_gain_r <= GAIN_RESET;
    end else if (wr_stb_in) begin
      if (hit_bass_set)    bass_set_r    <= wr_data_in;
      if (hit_bass_gain)   bass_gain_r   <= wr_data_in;
      // (R5) reserved treble bits held at zero
      if (hit_treble_set)  treble_set_r  <= wr_data_in & TREBLE_SET_MASK;
      // (R9) treble gain store
      if (hit_treble_gain) treble_gain_r <= wr_data_in;
    end
  end

  // read answer, stands until the next read
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rd_data_out <= 32'h00000000;
    end else if (rd_stb_in) begin
      rd_data_out <= rd_data_nxt;
    end
  end

  // ************************************************************
  // per-group corner selection and applied gain
  // ************************************************************
  genvar g;
  generate
    for (g = 0; g < NUM_GROUPS; g = g + 1) begin : grp
      // (R1) one byte per group, group 3 is channel 8
      // (R2) zero or illegal bass code keeps the corner
      tone_corner_slot u_bass (
        .sys_clk_in (sys_clk_in),
        .nrst_in    (nrst_in),
        .load_in    (wr_bass_set),
        .code_in    (wr_data_in[g*FIELD_W +: FIELD_W]),
        .corner_out (bass_corner_out[g*CODE_W +: CODE_W])
      );
      // (R6) treble groups decode only the low three bits
      tone_corner_slot u_treble (
        .sys_clk_in (sys_clk_in),
        .nrst_in    (nrst_in),
        .load_in    (wr_treble_set),
        .code_in    (wr_data_in[g*FIELD_W +: FIELD_W] & TREBLE_SET_MASK[7:0]),
        .corner_out (treble_corner_out[g*CODE_W +: CODE_W])
      );
      // (R12) bypass forces 0 dB; (R8) (R10) legal index passes, else clamps
      assign bass_eff_nxt[g*FIELD_W +: FIELD_W] = !tone_inline_in ? GAIN_ZERO_DB :
        (bass_gain_r[g*FIELD_W +: FIELD_W] > GAIN_MAX_INDEX) ? GAIN_MAX_INDEX :
        bass_gain_r[g*FIELD_W +: FIELD_W];
      assign treble_eff_nxt[g*FIELD_W +: FIELD_W] = !tone_inline_in ? GAIN_ZERO_DB :
        (treble_gain_r[g*FIELD_W +: FIELD_W] > GAIN_MAX_INDEX) ? GAIN_MAX_INDEX :
        treble_gain_r[g*FIELD_W +: FIELD_W];
    end
  endgenerate

  // applied gains and channel 6/5 routing
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bass_gain_index_out     <= GAIN_RESET;
      treble_gain_index_out   <= GAIN_RESET;
      surround_is_lineout_out <= 1'b0;
    end else begin
      bass_gain_index_out     <= bass_eff_nxt;
      treble_gain_index_out   <= treble_eff_nxt;
      // (R4) channel 6/5 field follows configuration
      surround_is_lineout_out <= six_channel_in;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);

  a_bass_gain_store: assert property ( // (R13)
    wr_stb_in && hit_bass_gain |=> bass_gain_r == $past(wr_data_in))
    else $error("bass gain write not stored");
  a_bass_set_store: assert property ( // (R14)
    wr_bass_set |=> bass_set_r == $past(wr_data_in))
    else $error("bass set write at its subaddress not stored");
  a_read_back: assert property ( // (R15)
    rd_stb_in && hit_treble_gain |=> rd_data_out == $past(treble_gain_r))
    else $error("treble gain read back wrong");
  a_keep_corner: assert property ( // (R2)
    wr_bass_set && wr_data_in[31:24] == 8'h00 |=> $stable(bass_corner_out[11:9]))
    else $error("code zero changed subwoofer corner");
  a_pick_corner: assert property ( // (R1)
    wr_bass_set && wr_data_in[31:24] inside {[8'h01:8'h05]}
    |=> bass_corner_out[11:9] == $past(wr_data_in[26:24]))
    else $error("subwoofer corner not selected");
  a_treble_reserved: assert property ( // (R5)
    wr_treble_set |=> (treble_set_r & ~TREBLE_SET_MASK) == 32'h00000000)
    else $error("treble reserved bits stored");
  a_treble_corner: assert property ( // (R6)
    wr_treble_set && wr_data_in[10:8] inside {3'h6, 3'h7}
    |=> $stable(treble_corner_out[5:3]))
    else $error("illegal treble code took effect");
  a_bypass_flat: assert property ( // (R12)
    !tone_inline_in |=> bass_gain_index_out == GAIN_RESET
                        && treble_gain_index_out == GAIN_RESET)
    else $error("tone applied while bypassed");
  a_gain_applied: assert property ( // (R8)
    tone_inline_in && wr_stb_in && hit_bass_gain && wr_data_in[7:0] <= 8'h24
    ##1 tone_inline_in |=> bass_gain_index_out[7:0] == $past(wr_data_in[7:0], 2))
    else $error("bass index not applied two cycles after write");
  a_treble_applied: assert property ( // (R10)
    tone_inline_in && treble_gain_r[31:24] <= 8'h24
    |=> treble_gain_index_out[31:24] == $past(treble_gain_r[31:24]))
    else $error("treble index not applied");
  a_lineout_route: assert property ( // (R4)
    six_channel_in |=> surround_is_lineout_out)
    else $error("surround field not routed to lineout");
  a_gain_reset: assert property ( // (R9)
    $rose(nrst_in) |-> treble_gain_r == GAIN_RESET)
    else $error("treble gain reset value wrong");

  // stores, read path, routing and reset of the other registers
  a_treble_gain_store: assert property ( // (R9)
    wr_stb_in && hit_treble_gain |=> treble_gain_r == $past(wr_data_in))
    else $error("treble gain write not stored");
  a_bass_read_back: assert property ( // (R15)
    rd_stb_in && hit_bass_gain |=> rd_data_out == $past(bass_gain_r))
    else $error("bass gain read back wrong");
  a_unmapped_read: assert property ( // (R15)
    rd_stb_in && !(hit_bass_set || hit_bass_gain || hit_treble_set || hit_treble_gain)
    |=> rd_data_out == 32'h00000000)
    else $error("unmapped read not zero");
  a_read_holds: assert property ( // (R15)
    !rd_stb_in |=> $stable(rd_data_out))
    else $error("read word changed without a read");
  a_surround_route: assert property ( // (R4)
    !six_channel_in |=> !surround_is_lineout_out)
    else $error("surround field on lineout in eight-channel mode");
  a_bass_gain_reset: assert property ( // (R7)
    $rose(nrst_in) |-> bass_gain_r == GAIN_RESET && bass_set_r == SET_RESET)
    else $error("bass reset values wrong");
  a_surround_corner: assert property ( // (R1)
    wr_bass_set && wr_data_in[23:16] inside {[8'h01:8'h05]}
    |=> bass_corner_out[8:6] == $past(wr_data_in[18:16]))
    else $error("surround pair corner not selected");
  a_rear_corner: assert property ( // (R1)
    wr_bass_set && wr_data_in[15:8] inside {[8'h01:8'h05]}
    |=> bass_corner_out[5:3] == $past(wr_data_in[10:8]))
    else $error("rear pair corner not selected");
  a_treble_keep: assert property ( // (R6)
    wr_treble_set && wr_data_in[26:24] == 3'h0 |=> $stable(treble_corner_out[11:9]))
    else $error("treble code zero changed subwoofer corner");

  c_bass_write: cover property (wr_stb_in && hit_bass_gain);
  c_corner_change: cover property (wr_bass_set ##1 $changed(bass_corner_out));
  c_inline_boost: cover property (tone_inline_in && bass_gain_index_out[31:24] == 8'h00);
  c_read_treble: cover property (rd_stb_in && hit_treble_set);
  c_six_channel: cover property (six_channel_in ##1 surround_is_lineout_out);
endmodule : tone_control_config_regs

// [bench/tone_host_model.sv]
// host controller model issuing register reads and writes
`timescale 1ns/1ps
module tone_host_model (
  input  wire logic        sys_clk_in,  // control clock
  input  wire logic [31:0] rd_data_in,  // read word from device
  output logic      [7:0]  subaddr_out, // register subaddress
  output logic             wr_stb_out,  // one-cycle write strobe
  output logic      [31:0] wr_data_out, // write word
  output logic             rd_stb_out   // one-cycle read strobe
);
  // idle bus at time zero
  initial begin
    subaddr_out = 8'h00;
    wr_stb_out  = 1'b0;
    wr_data_out = 32'h00000000;
    rd_stb_out  = 1'b0;
  end
  task automatic write_reg(input logic [7:0] addr, input logic [31:0] data);
    @(negedge sys_clk_in);
    subaddr_out = addr;
    wr_data_out = data;
    wr_stb_out  = 1'b1;
    @(negedge sys_clk_in);
    wr_stb_out  = 1'b0;
    // released lines show the inverse, not the old value
    wr_data_out = ~data;
    subaddr_out = ~addr;
  endtask : write_reg
  // read word lands one edge after the strobe
  task automatic read_reg(input logic [7:0] addr, output logic [31:0] data);
    @(negedge sys_clk_in);
    subaddr_out = addr;
    rd_stb_out  = 1'b1;
    @(negedge sys_clk_in);
    rd_stb_out  = 1'b0;
    subaddr_out = ~addr;
    data        = rd_data_in;
  endtask : read_reg
endmodule : tone_host_model

// [bench/tone_control_config_regs_test.sv]
// self-checking bench for the tone configuration registers
`timescale 1ns/1ps
module tone_control_config_regs_test
  import tone_regs_pkg::*;
;
  logic        sys_clk_in;     // 40 MHz control clock
  logic        nrst_in;        // reset, active low
  logic [7:0]  subaddr;        // host subaddress
  logic        wr_stb;         // host write strobe
  logic [31:0] wr_data;        // host write word
  logic        rd_stb;         // host read strobe
  logic        tone_inline_in; // bypass set inline
  logic        six_channel_in; // six-channel mode
  logic [31:0] rd_data;        // read word
  logic [11:0] bass_corner;    // bass corner sets
  logic [11:0] treble_corner;  // treble corner sets
  logic [31:0] bass_gain;      // applied bass indexes
  logic [31:0] treble_gain;    // applied treble indexes
  logic        lineout;        // surround pair on lineout
  int          mismatches;     // failed compares
  int          checks_done;    // all compares
  logic [31:0] word;           // last read word
  tone_control_config_regs dut_u (
    .sys_clk_in              (sys_clk_in),
    .nrst_in                 (nrst_in),
    .subaddr_in              (subaddr),
    .wr_stb_in               (wr_stb),
    .wr_data_in              (wr_data),
    .rd_stb_in               (rd_stb),
    .tone_inline_in          (tone_inline_in),
    .six_channel_in          (six_channel_in),
    .rd_data_out             (rd_data),
    .bass_corner_out         (bass_corner),
    .treble_corner_out       (treble_corner),
    .bass_gain_index_out     (bass_gain),
    .treble_gain_index_out   (treble_gain),
    .surround_is_lineout_out (lineout)
  );
  tone_host_model host_u (
    .sys_clk_in  (sys_clk_in),
    .rd_data_in  (rd_data),
    .subaddr_out (subaddr),
    .wr_stb_out  (wr_stb),
    .wr_data_out (wr_data),
    .rd_stb_out  (rd_stb)
  );
  // free-running clock, 25 ns period
  initial sys_clk_in = 1'b0;
  always #12.5 sys_clk_in = ~sys_clk_in;
  // compare one value, count and report a difference
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // read a register and compare it
  task automatic rd_check(input logic [7:0] addr, input logic [31:0] exp);
    host_u.read_reg(addr, word);
    check(word, exp);
  endtask : rd_check
  // print counts and verdict, then stop
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report
  // main sequence
  initial begin
    nrst_in        = 1'b0;
    tone_inline_in = 1'b0;
    six_channel_in = 1'b0;
    mismatches     = 0;
    checks_done    = 0;
    repeat (20) @(negedge sys_clk_in);
    nrst_in = 1'b1;
    // reset values, unmapped read
    rd_check(BASS_GAIN_ADDR, GAIN_RESET);
    rd_check(TREBLE_GAIN_ADDR, GAIN_RESET);
    rd_check(BASS_SET_ADDR, SET_RESET);
    rd_check(TREBLE_SET_ADDR, SET_RESET);
    rd_check(8'hDE, 32'h00000000);
    check({20'h00000, bass_corner}, 32'h00000249);
    check(bass_gain, GAIN_RESET);
    // bass codes two to five, one per group
    host_u.write_reg(BASS_SET_ADDR, 32'h05040302);
    check({20'h00000, bass_corner}, 32'h00000B1A);
    rd_check(BASS_SET_ADDR, 32'h05040302);
    // codes six and seven refused, code one taken
    host_u.write_reg(BASS_SET_ADDR, 32'h00070601);
    check({20'h00000, bass_corner}, 32'h00000B19);
    // treble uses low three bits only
    host_u.write_reg(TREBLE_SET_ADDR, 32'hFB0D0E01);
    check({20'h00000, treble_corner}, 32'h00000749);
    rd_check(TREBLE_SET_ADDR, 32'h03050601);
    // treble code zero keeps the other groups
    host_u.write_reg(TREBLE_SET_ADDR, 32'h00000002);
    check({20'h00000, treble_corner}, 32'h0000074A);
    tone_inline_in = 1'b1;
    host_u.write_reg(BASS_GAIN_ADDR, 32'h00122324);
    host_u.write_reg(TREBLE_GAIN_ADDR, 32'h24001211);
    @(negedge sys_clk_in);
    check(bass_gain, 32'h00122324);
    check(treble_gain, 32'h24001211);
    rd_check(BASS_GAIN_ADDR, 32'h00122324);
    rd_check(TREBLE_GAIN_ADDR, 32'h24001211);
    // bypass shows 0 dB everywhere
    tone_inline_in = 1'b0;
    @(negedge sys_clk_in);
    check(bass_gain, GAIN_RESET);
    check(treble_gain, GAIN_RESET);
    // surround pair routing by configuration
    six_channel_in = 1'b1;
    @(negedge sys_clk_in);
    check({31'h00000000, lineout}, 32'h00000001);
    six_channel_in = 1'b0;
    @(negedge sys_clk_in);
    check({31'h00000000, lineout}, 32'h00000000);
    // reset in mid-run brings every register back
    host_u.write_reg(BASS_GAIN_ADDR, 32'h01020304);
    nrst_in = 1'b0;
    @(negedge sys_clk_in);
    nrst_in = 1'b1;
    check({20'h00000, bass_corner}, 32'h00000249);
    check({20'h00000, treble_corner}, 32'h00000249);
    check(rd_data, 32'h00000000);
    rd_check(BASS_GAIN_ADDR, GAIN_RESET);
    rd_check(TREBLE_SET_ADDR, SET_RESET);
    final_report();
  end
endmodule : tone_control_config_regs_test
